//--- hw/sac_pkg.sv
// Package for the converter trigger and channel control block.
// Assumes an AXI4-Lite slave with 32-bit data and one clock.
package sac_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_PCH    = 8'h0c;
  localparam logic [7:0] OFS_NCH    = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // Control field positions
  localparam int CTL_TRIG_LO = 0;
  localparam int CTL_CFG_LO  = 3;
  localparam int CTL_EN_BIT  = 7;

  // Result field placement
  localparam int RES_LO   = 16;
  localparam int RES_BITS = 12;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CH_RST   = 8'h00;

  // Acquisition time
  localparam int ACQ_NS       = 1000;
  localparam int CLK_NS       = 50;
  localparam int ACQ_CYC      = (ACQ_NS + CLK_NS - 1) / CLK_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TRG_PIN  = 3'h0,
    TRG_TMR1 = 3'h1,
    TRG_TMR0 = 3'h2,
    TRG_SW1  = 3'h3,
    TRG_SWC  = 3'h4,
    TRG_PLA  = 3'h5
  } sac_trig_t;

  typedef enum logic [1:0] {
    CFG_SE   = 2'h0,
    CFG_DIFF = 2'h1,
    CFG_PSD  = 2'h2
  } sac_cfg_t;

  localparam logic [4:0] PCH_MAX  = 5'h13;
  localparam logic [4:0] NCH_MAX  = 5'h10;

  // Switch drive to the analog front end
  typedef struct packed {
    logic       balance_closed;
    logic       pos_track;
    logic       neg_to_input;
    logic       neg_to_ref;
    logic       neg_to_gnd;
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;
  } sac_sw_t;

endpackage

//--- hw/sac_ctrl.sv
// Trigger, channel select and phase sequencer for a 12-bit SAR converter.
// Assumes synchronous trigger inputs and a comparator that settles within
// the cycle in which sar_trial shows a trial code.
//
// Contract
// - Trigger field 000 pin, 001 timer1, 010 timer0, 011 single, 100 continuous, 101 array.
// - Negative select bits 4-0; 0-15 inputs, 16 reference.
// - Acquisition keeps comparator balanced while sampling arrays track input.
// - Conversion start disconnects both inputs for whole conversion.
// - Successive approximation steps until balanced, then code is output.
// - Pseudo-differential negative switch: input in acquisition, reference converting.
// - Single-ended negative switch tied to ground; negative pin ignored.
// - Control bits 4-3 pick single, differential, pseudo; 11 reserved.
// - Control bit 7 enables conversion mode.
// - Status bit 0 set at end of conversion; cleared by result read.
// - Result in bits 27-16, sign above; two's complement only differential.
`timescale 1ns/1ps
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int ACQ_CYCLES = ACQ_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trigger sources
  input  wire logic        external_start_pin,
  input  wire logic        timer1_overflow,
  input  wire logic        timer0_overflow,
  input  wire logic        programmable_logic_array,
  // Analog front end
  input  wire logic        comparator_high,
  output sac_sw_t          switch_ctl,
  output logic [11:0]      sar_trial,
  output logic             busy,
  output logic             irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} sac_state_t;

  logic [7:0]  ctrl_r;
  logic [4:0]  pch_r;
  logic [4:0]  nch_r;
  logic        stat_r;
  logic        mask_r;
  logic [11:0] result_r;
  sac_state_t  state_r;
  logic [15:0] acq_cnt_r;
  logic [3:0]  bit_r;
  logic [11:0] trial_r;
  logic        pend_sw_r;
  logic        trig_prev_r;
  logic        done_pulse;
  logic        start_req;
  logic        trig_lvl;
  logic        conv_nxt;
  logic [11:0] kept;
  logic [11:0] trial_nxt;
  logic        wr_go;
  logic        rd_go;
  logic        data_read;
  logic [7:0]  aw_r;
  logic [31:0] w_r;
  logic [3:0]  ws_r;
  logic        aw_have_r;
  logic        w_have_r;
  sac_trig_t   trig_sel;
  sac_cfg_t    cfg_sel;

  assign trig_sel = sac_trig_t'(ctrl_r[CTL_TRIG_LO +: 3]);
  assign cfg_sel  = sac_cfg_t'(ctrl_r[CTL_CFG_LO +: 2]);

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel, address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_r      <= 8'h00;
      w_r       <= 32'h0;
      ws_r      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_r      <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_r      <= s_axi_wdata;
        ws_r     <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_r[7:2] > OFS_MASK[7:2]) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; byte lane 0 carries all writable fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      pch_r  <= CH_RST[4:0];
      nch_r  <= CH_RST[4:0];
      mask_r <= 1'b0;
    end else if (wr_go && ws_r[0]) begin
      case ({aw_r[7:2], 2'b00})
        OFS_CTRL: ctrl_r <= w_r[7:0];
        OFS_PCH:  pch_r  <= w_r[4:0];
        OFS_NCH:  nch_r  <= w_r[4:0];
        OFS_MASK: mask_r <= w_r[0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go     = s_axi_arvalid && s_axi_arready;
  assign data_read = rd_go && ({s_axi_araddr[7:2], 2'b00} == OFS_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_CTRL: s_axi_rdata <= {24'h0, ctrl_r};
        OFS_STAT: s_axi_rdata <= {31'h0, stat_r};
        // Sign copies above the code, only in differential mode
        OFS_DATA: s_axi_rdata <= {{4{cfg_sel == CFG_DIFF && result_r[11]}},
                                  result_r, 16'h0};
        OFS_PCH:  s_axi_rdata <= {27'h0, pch_r};
        OFS_NCH:  s_axi_rdata <= {27'h0, nch_r};
        OFS_MASK: s_axi_rdata <= {31'h0, mask_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger selection; edge of a hardware source starts one conversion
  always_comb begin
    case (trig_sel)
      TRG_PIN:  trig_lvl = external_start_pin;
      TRG_TMR1: trig_lvl = timer1_overflow;
      TRG_TMR0: trig_lvl = timer0_overflow;
      TRG_PLA:  trig_lvl = programmable_logic_array;
      default:  trig_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) trig_prev_r <= 1'b0;
    else          trig_prev_r <= trig_lvl;
  end

  // Single software request armed by writing the control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_sw_r <= 1'b0;
    end else if (wr_go && ws_r[0] && {aw_r[7:2], 2'b00} == OFS_CTRL) begin
      pend_sw_r <= (w_r[2:0] == TRG_SW1);
    end else if (state_r == ST_ACQ) begin
      pend_sw_r <= 1'b0;
    end
  end

  // Reserved trigger codes and reserved configuration never start
  always_comb begin
    start_req = 1'b0;
    if (ctrl_r[CTL_EN_BIT] && ctrl_r[4:3] != 2'b11) begin
      case (trig_sel)
        TRG_SW1: start_req = pend_sw_r;
        TRG_SWC: start_req = 1'b1;
        TRG_PIN, TRG_TMR1, TRG_TMR0, TRG_PLA:
          start_req = trig_lvl && !trig_prev_r;
        default: start_req = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Phase sequencer: idle, acquisition, successive approximation
  // Outputs are registered from next-state terms and change on the same edge as the state,
  // so the DACs and the comparator see a trial code in the very cycle in which its bit is decided
  assign kept = comparator_high ? trial_r : (trial_r & ~(12'h1 << bit_r));
  assign conv_nxt = (state_r == ST_ACQ && acq_cnt_r == 16'(ACQ_CYCLES - 1))
                    || (state_r == ST_CONV && bit_r != 4'h0);
  assign trial_nxt = (state_r == ST_ACQ) ? 12'h800
                   : (state_r == ST_CONV && bit_r != 4'h0)
                     ? (kept | (12'h1 << (bit_r - 4'h1))) : trial_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= ST_IDLE;
      acq_cnt_r <= 16'h0;
      bit_r     <= 4'h0;
      trial_r   <= 12'h0;
      result_r  <= 12'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            state_r   <= ST_ACQ;
            acq_cnt_r <= 16'h0;
          end
        end
        ST_ACQ: begin
          if (acq_cnt_r == 16'(ACQ_CYCLES - 1)) begin
            state_r <= ST_CONV;
            bit_r   <= 4'd11;
            trial_r <= 12'h800;
          end else begin
            acq_cnt_r <= acq_cnt_r + 16'h1;
          end
        end
        ST_CONV: begin
          trial_r <= trial_nxt;
          if (bit_r == 4'h0) begin
            result_r <= kept;
            state_r  <= ST_IDLE;
          end else begin
            bit_r <= bit_r - 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign done_pulse = (state_r == ST_CONV) && (bit_r == 4'h0);

  // Set wins over a clearing read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)        stat_r <= 1'b0;
    else if (done_pulse) stat_r <= 1'b1;
    else if (data_read)  stat_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs to the front end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_ctl <= '0;
      sar_trial  <= 12'h0;
      busy       <= 1'b0;
      irq        <= 1'b0;
    end else begin
      switch_ctl.balance_closed <= !conv_nxt;
      switch_ctl.pos_track      <= !conv_nxt;
      switch_ctl.neg_to_input   <= !conv_nxt
                                   && cfg_sel != CFG_SE;
      switch_ctl.neg_to_ref     <= conv_nxt
                                   && cfg_sel == CFG_PSD;
      switch_ctl.neg_to_gnd     <= (cfg_sel == CFG_SE);
      switch_ctl.pos_sel        <= pch_r;
      switch_ctl.neg_sel        <= nch_r;
      sar_trial                 <= trial_nxt;
      busy                      <= (state_r != ST_IDLE);
      irq                       <= (stat_r || done_pulse) && mask_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sample_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_CONV |-> !switch_ctl.pos_track
                           && !switch_ctl.balance_closed)
    else $error("input tracked during conversion");

  balance_acq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_ACQ |-> switch_ctl.balance_closed)
    else $error("comparator not balanced in acquisition");

  conv_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_r == ST_CONV) |-> (state_r == ST_CONV) [*8])
    else $error("conversion ended early");

  done_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_pulse |=> stat_r)
    else $error("status not set at end of conversion");

  read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    data_read && !done_pulse |=> !stat_r)
    else $error("status not cleared by result read");

  se_ground_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_sel == CFG_SE |=> switch_ctl.neg_to_gnd
                          && !switch_ctl.neg_to_input)
    else $error("negative side not grounded");

  pseudo_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_CONV && $past(cfg_sel) == CFG_PSD
    |-> switch_ctl.neg_to_ref)
    else $error("negative side not on reference");

  disabled_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_IDLE && !ctrl_r[CTL_EN_BIT] |=> state_r == ST_IDLE)
    else $error("conversion started while disabled");

  reserved_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[2:0] > 3'h5 |-> !start_req)
    else $error("reserved trigger started a conversion");

  reserved_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[4:3] == 2'b11 |-> !start_req)
    else $error("reserved configuration started a conversion");

  chan_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 switch_ctl.pos_sel == $past(pch_r)
        && switch_ctl.neg_sel == $past(nch_r))
    else $error("channel select not driven");

  sign_ext_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && {s_axi_araddr[7:2], 2'b00} == OFS_DATA && cfg_sel != CFG_DIFF
    |=> s_axi_rdata[31:28] == 4'h0 && s_axi_rdata[15:0] == 16'h0)
    else $error("straight binary result has sign bits");

endmodule

//--- sim/sac_afe_model.sv
// Behavioural analog front end: sampling switch, held sample, comparator.
// Assumes switch_ctl and sar_trial come straight from the control block.
`timescale 1ns/1ps
module sac_afe_model
  import sac_pkg::*;
(
  // Clock
  input  wire logic        aclk,
  // From the control block
  input  wire sac_sw_t     switch_ctl,
  input  wire logic [11:0] sar_trial,
  // From the bench
  input  wire logic [11:0] analog_level,
  // To the control block
  output logic             comparator_high
);
  ////////////////////////////////////////////////////////////////////////
  logic [11:0] held_r;
  logic        tgl_r = 1'b0;

  always_ff @(posedge aclk) begin
    // Track while connected, hold once disconnected
    if (switch_ctl.pos_track) begin
      held_r <= analog_level;
    end
    tgl_r <= ~tgl_r;
  end

  // Balanced comparator decides nothing, so toggle to expose misuse
  assign comparator_high = switch_ctl.balance_closed ? tgl_r
                                                     : (held_r >= sar_trial);
endmodule

//--- sim/tb_sar_adc_trigger_channel_control.sv
// Self-checking bench for the converter trigger and channel control block.
// Assumes sac_pkg, sac_ctrl and the front end model are compiled first.
`timescale 1ns/1ps
module tb_sar_adc_trigger_channel_control
  import sac_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  localparam int ACQ_N = 2;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  src;
  logic        cmp_high, busy, irq, prev_busy, cont;
  sac_sw_t     sw;
  logic [11:0] trial, lvl;
  logic [1:0]  cfg_now;
  logic [33:0] bq[$];
  logic [33:0] rq[$];
  logic [31:0] st;
  int          n_fail = 0;
  int          n_compared = 0;
  int          bcnt = 0;

  sac_ctrl #(.ACQ_CYCLES(ACQ_N)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_start_pin(src[0]), .timer1_overflow(src[1]),
    .timer0_overflow(src[2]), .programmable_logic_array(src[3]),
    .comparator_high(cmp_high), .switch_ctl(sw), .sar_trial(trial),
    .busy(busy), .irq(irq));

  sac_afe_model afe (.aclk(aclk), .switch_ctl(sw), .sar_trial(trial),
    .analog_level(lvl), .comparator_high(cmp_high));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  task automatic chk(logic [33:0] seen, logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each channel released only when its own ready is seen
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] rsp);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    bq.push_back({rsp, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [33:0] exp);
    @(posedge aclk);
    rq.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic pulse(logic [3:0] m);
    @(posedge aclk);
    src <= m;
    repeat (2) @(posedge aclk);
    src <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watcher: oldest bus note against each response as it appears
  always @(posedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0}, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
  end

  // Watcher: switch phases; first busy cycle skipped as a launch edge
  always @(posedge aclk) begin
    if (busy && prev_busy && sw.pos_track) begin
      chk(sw.balance_closed, 1'b1);
      if (cfg_now == 2'h0) chk(sw.neg_to_gnd, 1'b1);
      if (cfg_now == 2'h2) chk(sw.neg_to_input, 1'b1);
    end
    if (busy && prev_busy && !sw.pos_track) begin
      chk({sw.balance_closed, sw.neg_to_input}, 2'b00);
      if (cfg_now == 2'h0) chk(sw.neg_to_gnd, 1'b1);
      if (cfg_now == 2'h2) chk(sw.neg_to_ref, 1'b1);
    end
    if (busy) bcnt++;
    else begin
      if (prev_busy && !cont)
        chk(bcnt >= ACQ_N + 12 && bcnt <= ACQ_N + 13, 1'b1);
      bcnt = 0;
    end
    prev_busy = busy;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  ofs [5];
    logic [2:0]  code;
    logic [1:0]  cfg;
    logic [1:0]  sb;
    logic [4:0]  p, n;
    logic [11:0] v;
    logic        conv;
    st = 32'd83;
    ofs = '{OFS_CTRL, OFS_STAT, OFS_DATA, OFS_PCH, OFS_MASK};
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, src, lvl, cont, cfg_now} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], {RESP_OKAY, 32'h0});
    rd(8'h18, {RESP_SLVERR, 32'h0});
    wr(8'h18, 32'h1, RESP_SLVERR);
    wr(OFS_MASK, 32'h1, RESP_OKAY);
    rd(OFS_MASK, {RESP_OKAY, 32'h1});
    // Codes 0..5 convert; reserved codes, cfg 11 and disabled must not
    for (int i = 0; i < 10; i++) begin
      code = (i < 8) ? 3'(i) : ((i == 8) ? 3'h3 : 3'h4);
      cfg = (i == 8) ? 2'h3 : 2'(i % 3);
      conv = (i < 6);
      sb = (code == 3'h5) ? 2'd3 : code[1:0];
      v = 12'(rnd());
      lvl <= v;
      p = 5'(rnd() % 20);
      n = 5'(rnd() % 17);
      wr(OFS_PCH, {27'h0, p}, RESP_OKAY);
      // Select output is launched at the edge the write task returns on
      @(negedge aclk);
      chk(sw.pos_sel, p);
      rd(OFS_PCH, {RESP_OKAY, 27'h0, p});
      wr(OFS_NCH, {27'h0, n}, RESP_OKAY);
      @(negedge aclk);
      chk(sw.neg_sel, n);
      cfg_now = cfg;
      cont = (code == 3'h4);
      wr(OFS_CTRL, {24'h0, (i != 9), 2'b00, cfg, code}, RESP_OKAY);
      if (!conv || code < 3'h3 || code == 3'h5) begin
        pulse(conv ? ~(4'h1 << sb) : 4'hf);
        repeat (30) @(posedge aclk);
        chk(irq, 1'b0);
      end
      if (conv && code != 3'h3 && code != 3'h4) pulse(4'h1 << sb);
      if (conv) begin
        repeat (300) if (irq !== 1'b1) @(posedge aclk);
        chk(irq, 1'b1);
        rd(OFS_STAT, {RESP_OKAY, 32'h1});
        if (cont) begin
          // Stop by enable only; the mode still decides the result coding
          wr(OFS_CTRL, {24'h0, 3'b000, cfg, code}, RESP_OKAY);
          repeat (40) @(posedge aclk);
        end
        rd(OFS_DATA, {RESP_OKAY, (cfg == 2'h1) ? {4{v[11]}} : 4'h0,
                      v, 16'h0});
        rd(OFS_STAT, {RESP_OKAY, 32'h0});
        chk(irq, 1'b0);
      end
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      cont = 1'b0;
    end
    // Masked: status still set, interrupt held low
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    cfg_now = 2'h0;
    wr(OFS_CTRL, 32'h83, RESP_OKAY);
    repeat (40) @(posedge aclk);
    chk(irq, 1'b0);
    rd(OFS_STAT, {RESP_OKAY, 32'h1});
    rd(OFS_DATA, {RESP_OKAY, 4'h0, v, 16'h0});
    close_out();
  end
endmodule
